// *** fsal_top.sv ***
/*
 * Fault status aggregation, alert masking, fault-line propagation and
 * telemetry log control for a two-channel controller.
 * Assumes: fault events arrive as one-cycle pulses from local logic,
 * fault lines and the link clock come from outside and are synchronised.
 */
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module fsal_top #(
    parameter int RETRY_COUNT = fsal_pkg::RETRY_CYCLES
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    input  wire logic [7:0]       addr_i,
    input  wire logic [15:0]      wdata_i,
    output logic [15:0]           rdata_o,
    input  wire logic [2*32-1:0]  fault_event_i,   // per channel cat events
    input  wire logic [1:0]       fault_active_i,  // fault condition still present
    input  wire logic [1:0]       ch_enabled_i,
    input  wire logic [8:0]       die_temp_i,
    input  wire logic             link_clk_i,       // sampled only
    input  wire logic [1:0]       fault_line_i,
    output logic [1:0]            fault_line_o,
    output logic [1:0]            fault_line_oe_n_o,
    output logic                  alert_n_o,
    output logic [1:0]            ch_shutdown_o,
    output logic [1:0]            soft_start_o,
    output logic                  nvm_copy_o
);
    // ==========================================================
    // elaboration checks
    if (RETRY_COUNT < 1) begin : g_chk
        $error("retry count must be positive");
    end

    // ==========================================================
    // input synchronisers
    logic [1:0] line_s1, line_s2, clk_s1, clk_s2, clk_s3;
    always_ff @(posedge clock_i) begin
        line_s1 <= fault_line_i;
        line_s2 <= line_s1;
        clk_s1  <= {1'b0, link_clk_i};
        clk_s2  <= clk_s1;
        clk_s3  <= clk_s2;
    end
    wire link_rise = clk_s2[0] & ~clk_s3[0]; // edge of the serial clock

    // ==========================================================
    // bus decode
    fsal_pkg::fsal_bus_t bus;
    assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
    wire cmd_wr = bus.wr && bus.addr == fsal_pkg::ADDR_COMMAND;
    wire clear_all = cmd_wr && (bus.wdata[fsal_pkg::CMD_CLEAR_FAULTS]
        || bus.wdata[fsal_pkg::CMD_RESTORE_ALL] || bus.wdata[fsal_pkg::CMD_RESTART]);
    wire clear_faults = cmd_wr && bus.wdata[fsal_pkg::CMD_CLEAR_FAULTS];
    // acknowledge counts only once the address goes out on a link edge
    logic ara_pend;
    always_ff @(posedge clock_i) begin
        if (reset_i)
            ara_pend <= 1'b0;
        else if (cmd_wr && bus.wdata[fsal_pkg::CMD_ARA_DONE])
            ara_pend <= 1'b1;
        else if (link_rise)
            ara_pend <= 1'b0;
    end
    wire ara_done = ara_pend & link_rise;

    // ==========================================================
    // channel on/off tracking
    logic [1:0] ctrl_on, on_prev;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_on <= 2'b00;
            on_prev <= 2'b00;
        end else begin
            if (bus.wr && bus.addr == fsal_pkg::ADDR_CONTROL)
                ctrl_on <= bus.wdata[1:0];
            on_prev <= ctrl_on;
        end
    end
    wire [1:0] ch_cycled = ctrl_on & ~on_prev; // off then on

    // ==========================================================
    // per-category status and mask, set wins over clear
    fsal_pkg::fsal_cat_t status [2];
    fsal_pkg::fsal_cat_t mask [2];
    logic [15:0] pin_status, common_status;
    logic busy, valid_set;
    genvar gc;
    for (gc = 0; gc < 2; gc++) begin : g_ch
        wire slave = |pin_status[fsal_pkg::PIN_SLAVE_LO+1:fsal_pkg::PIN_SLAVE_LO];
        wire [31:0] ev_raw = fault_event_i[gc*32 +: 32];
        // slave channels only report the error amp fault as overvoltage
        wire [31:0] ev = slave ? {ev_raw[31:24] & 8'h80, ev_raw[23:0]} : ev_raw;
        wire [7:0] wsel = bus.addr - fsal_pkg::ADDR_CAT_BASE - 8'(gc*4);
        wire hit = bus.wr && (wsel < 8'h04);
        wire [7:0] msel = bus.addr - fsal_pkg::ADDR_MASK_BASE - 8'(gc*4);
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                status[gc] <= '0;
                mask[gc]   <= '{default: fsal_pkg::MASK_RESET};
            end else begin
                for (int k = 0; k < 4; k++) begin
                    logic [7:0] cur, clr;
                    cur = status[gc][31-8*k -: 8];
                    clr = (hit && wsel == 8'(k)) ? bus.wdata[7:0] : 8'h00;
                    if (clear_all || ch_cycled[gc])
                        cur = 8'h00;
                    status[gc][31-8*k -: 8] <= (cur & ~clr) | ev[31-8*k -: 8];
                    if (bus.wr && msel == 8'(k))
                        mask[gc][31-8*k -: 8] <= bus.wdata[7:0];
                end
                if (gc == 0 && valid_set)
                    status[gc].mfr[fsal_pkg::MFR_LOG_BIT] <= 1'b1;
            end
        end
    end

    // busy bit: unsafe command while any channel runs
    always_ff @(posedge clock_i) begin
        if (reset_i)
            busy <= 1'b0;
        else if (cmd_wr && bus.wdata[fsal_pkg::CMD_UNSAFE] && |ch_enabled_i)
            busy <= 1'b1;
        else if (clear_all || (bus.wr && bus.addr == fsal_pkg::ADDR_STATUS_BYTE
                 && bus.wdata[fsal_pkg::SB_BUSY]))
            busy <= 1'b0;
    end

    // pin and common status: never feed the alert; pin status [15:14] selects the slave event filter
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_status    <= 16'h0000;
            common_status <= 16'h0000;
        end else begin
            if (bus.wr && bus.addr == fsal_pkg::ADDR_PINS)
                pin_status <= bus.wdata;
            common_status <= {12'h000, busy, 1'b0, ch_enabled_i};
        end
    end

    // ==========================================================
    // summary word and alert
    logic [15:0] status_word;
    logic [3:0]  sum_unmasked;
    always_comb begin
        status_word  = 16'h0000;
        sum_unmasked = 4'h0;
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 4; k++) begin
                status_word[15-k] = status_word[15-k] | (|status[c][31-8*k -: 8]);
                // an all-masked category still raises its summary bit but cannot raise the alert
                sum_unmasked[k] = sum_unmasked[k]
                    | (|(status[c][31-8*k -: 8] & ~mask[c][31-8*k -: 8]));
            end
        end
        status_word[fsal_pkg::SB_BUSY] = busy;
        status_word[fsal_pkg::SB_NONE_ABOVE] = |status_word[15:12];
    end
    wire alert_cause = |sum_unmasked | busy;

    logic alert_latch;
    always_ff @(posedge clock_i) begin
        if (reset_i)
            alert_latch <= 1'b0;
        else if (alert_cause && !alert_latch)
            alert_latch <= 1'b1;
        else if (!alert_cause || ara_done)
            alert_latch <= 1'b0;
    end
    always_ff @(posedge clock_i) begin
        if (reset_i)
            alert_n_o <= 1'b1;
        else
            alert_n_o <= ~(alert_latch & ~ara_done);
    end

    // ==========================================================
    // fault lines
    logic [15:0] line_map;
    logic [7:0]  line_resp;
    logic [1:0]  line_hold;
    logic [$clog2(fsal_pkg::RETRY_CYCLES+1)+1:0] retry_cnt [2];
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            line_map  <= fsal_pkg::MAP_RESET;
            line_resp <= fsal_pkg::RESP_RESET;
        end else if (bus.wr && bus.addr == fsal_pkg::ADDR_LINE_MAP)
            line_map <= bus.wdata;
        else if (bus.wr && bus.addr == fsal_pkg::ADDR_LINE_RESP)
            line_resp <= bus.wdata[7:0];
    end
    wire [1:0] mapped = {|({status[1].vout[7:4], status[1].iout[7:4]} & line_map[15:8]),
                         |({status[0].vout[7:4], status[0].iout[7:4]} & line_map[7:0])};
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            line_hold    <= 2'b00;
            retry_cnt    <= '{default: '0};
            soft_start_o <= 2'b00;
        end else begin
            soft_start_o <= 2'b00;
            for (int c = 0; c < 2; c++) begin
                if (mapped[c] && !line_hold[c]) begin
                    line_hold[c] <= 1'b1;
                    retry_cnt[c] <= '0;
                end else if (line_hold[c]) begin
                    if (line_resp == fsal_pkg::RESP_RETRY) begin
                        if (retry_cnt[c] < RETRY_COUNT)
                            retry_cnt[c] <= retry_cnt[c] + 1'b1;
                        else if (!fault_active_i[c]) begin
                            line_hold[c] <= 1'b0;
                            soft_start_o <= 2'b11;
                        end
                    end else if (!mapped[c])
                        line_hold[c] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            fault_line_o      <= 2'b00;
            fault_line_oe_n_o <= 2'b11;
            ch_shutdown_o     <= 2'b00;
        end else begin
            fault_line_o      <= 2'b00;
            fault_line_oe_n_o <= ~line_hold;
            // synchronised line read directly, no filter
            ch_shutdown_o <= (line_resp == fsal_pkg::RESP_SHUTDOWN && ~&line_s2)
                             ? 2'b11 : 2'b00;
        end
    end

    // ==========================================================
    // telemetry log
    logic [7:0] log_ram [fsal_pkg::LOG_LEN];
    logic [7:0] wr_ptr, rd_ptr;
    fsal_pkg::fsal_log_state_t log_state;
    logic log_exists, log_block, partial;
    // only internal category events trigger; line faults never reach here
    wire trig = |(fault_event_i & {2{32'hF0F0_0000}}) & |ch_enabled_i;
    wire hot  = die_temp_i > 9'(fsal_pkg::TEMP_HIGH_C);
    wire cool = die_temp_i < 9'(fsal_pkg::TEMP_LOW_C);
    logic hot_hold;
    always_ff @(posedge clock_i) begin
        if (reset_i) hot_hold <= 1'b0;
        else if (hot) hot_hold <= 1'b1;
        else if (cool) hot_hold <= 1'b0;
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            log_state  <= fsal_pkg::FSAL_LOG_RUN;
            log_exists <= 1'b0;
            log_block  <= 1'b0;
            partial    <= 1'b0;
            valid_set  <= 1'b0;
            nvm_copy_o <= 1'b0;
            wr_ptr     <= 8'(fsal_pkg::HDR_LEN);
        end else begin
            valid_set  <= 1'b0;
            nvm_copy_o <= 1'b0;
            if (cmd_wr && bus.wdata[fsal_pkg::CMD_NVM_VALID]) begin
                log_exists <= 1'b1;
                log_block  <= 1'b1;
                valid_set  <= 1'b1;
                partial    <= bus.wdata[fsal_pkg::CMD_NVM_PARTIAL];
                log_state  <= fsal_pkg::FSAL_LOG_HELD;
            end else if (clear_faults && !partial) begin
                log_block <= 1'b0;
                log_state <= fsal_pkg::FSAL_LOG_RUN;
            end else if (cmd_wr && bus.wdata[fsal_pkg::CMD_LOG_ERASE]) begin
                log_exists <= 1'b0;
                partial    <= 1'b0;
                log_block  <= 1'b0;
                log_state  <= fsal_pkg::FSAL_LOG_RUN;
            end else case (log_state)
                fsal_pkg::FSAL_LOG_RUN: begin
                    if (trig && !log_block) begin
                        log_exists <= 1'b1;
                        log_state  <= fsal_pkg::FSAL_LOG_FROZEN;
                    end else if (bus.wr && bus.addr == fsal_pkg::ADDR_RECORD_IN) begin
                        // records wrap over six slots after the header
                        wr_ptr <= (wr_ptr == 8'(fsal_pkg::LOG_LEN - 1))
                                  ? 8'(fsal_pkg::HDR_LEN) : wr_ptr + 8'h01;
                    end
                end
                fsal_pkg::FSAL_LOG_FROZEN:
                    if (!hot_hold) log_state <= fsal_pkg::FSAL_LOG_COPY;
                fsal_pkg::FSAL_LOG_COPY: begin
                    nvm_copy_o <= 1'b1;
                    log_block  <= 1'b1;
                    log_state  <= fsal_pkg::FSAL_LOG_HELD;
                end
                fsal_pkg::FSAL_LOG_HELD: ;
                default: log_state <= fsal_pkg::FSAL_LOG_RUN;
            endcase
        end
    end
    always_ff @(posedge clock_i) begin
        if (log_state == fsal_pkg::FSAL_LOG_RUN && bus.wr
            && bus.addr == fsal_pkg::ADDR_RECORD_IN)
            log_ram[wr_ptr] <= bus.wdata[7:0];
    end

    // ==========================================================
    // read mux, data one cycle after strobe
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
            rd_ptr  <= 8'h00;
        end else begin
            rdata_o <= 16'h0000;
            if (bus.rd) begin
                case (bus.addr)
                    fsal_pkg::ADDR_STATUS_BYTE: rdata_o <= {8'h00, status_word[7:0]};
                    fsal_pkg::ADDR_STATUS_WORD: rdata_o <= status_word;
                    fsal_pkg::ADDR_COMMON:      rdata_o <= common_status;
                    fsal_pkg::ADDR_PINS:        rdata_o <= pin_status;
                    fsal_pkg::ADDR_LINE_MAP:    rdata_o <= line_map;
                    fsal_pkg::ADDR_LINE_RESP:   rdata_o <= {8'h00, line_resp};
                    fsal_pkg::ADDR_LOG_STATE:   rdata_o <= {10'h000, partial,
                                                    log_exists, log_state};
                    fsal_pkg::ADDR_LOG_COUNT: begin
                        rd_ptr  <= 8'h00;
                        rdata_o <= (log_exists && log_state != fsal_pkg::FSAL_LOG_RUN)
                            ? 16'(fsal_pkg::LOG_LEN) : 16'h0000;
                    end
                    fsal_pkg::ADDR_LOG_DATA: begin
                        rdata_o <= {8'h00, log_ram[rd_ptr]};
                        rd_ptr  <= (rd_ptr == 8'(fsal_pkg::LOG_LEN - 1))
                                   ? 8'h00 : rd_ptr + 8'h01;
                    end
                    default: begin
                        if (bus.addr[7:4] == 4'h1)
                            rdata_o <= {8'h00, status[bus.addr[2]][31-8*bus.addr[1:0] -: 8]};
                        else if (bus.addr[7:4] == 4'h2)
                            rdata_o <= {8'h00, mask[bus.addr[2]][31-8*bus.addr[1:0] -: 8]};
                    end
                endcase
            end
        end
    end

endmodule : fsal_top

// *** fsal_pkg.sv ***
/*
 * Package for the fault status, alert and log block: command codes,
 * status bit positions, reset values, log geometry and carrier structs.
 * Assumes one clock domain; the host command port is a plain strobed port.
 */
package fsal_pkg;

    // ==========================================================
    // command port addresses (plain register port, word wide)
    localparam logic [7:0] ADDR_STATUS_BYTE  = 8'h00;
    localparam logic [7:0] ADDR_STATUS_WORD  = 8'h01;
    localparam logic [7:0] ADDR_CAT_BASE     = 8'h10; // +ch*4+cat: per-category status
    localparam logic [7:0] ADDR_MASK_BASE    = 8'h20; // +ch*4+cat: per-category alert mask
    localparam logic [7:0] ADDR_COMMON       = 8'h30;
    localparam logic [7:0] ADDR_PINS         = 8'h31;
    localparam logic [7:0] ADDR_LINE_MAP     = 8'h32; // [7:0] ch0, [15:8] ch1
    localparam logic [7:0] ADDR_LINE_RESP    = 8'h33;
    localparam logic [7:0] ADDR_CONTROL      = 8'h34; // [1:0] channel on commands
    localparam logic [7:0] ADDR_COMMAND      = 8'h35; // write: one-shot commands
    localparam logic [7:0] ADDR_LOG_COUNT    = 8'h36; // read: block byte count
    localparam logic [7:0] ADDR_LOG_DATA     = 8'h37; // read: next log byte
    localparam logic [7:0] ADDR_LOG_STATE    = 8'h38;
    localparam logic [7:0] ADDR_RECORD_IN    = 8'h39; // write: telemetry byte into log

    // one-shot command bits written to ADDR_COMMAND
    localparam int CMD_CLEAR_FAULTS = 0;
    localparam int CMD_RESTORE_ALL  = 1;
    localparam int CMD_RESTART      = 2;
    localparam int CMD_LOG_ERASE    = 3;
    localparam int CMD_ARA_DONE     = 4;
    localparam int CMD_UNSAFE       = 5;
    localparam int CMD_NVM_VALID    = 6;
    localparam int CMD_NVM_PARTIAL  = 7;

    // status byte / word bit positions
    localparam int SB_NONE_ABOVE = 0;
    localparam int SB_BUSY       = 7;
    localparam int SW_VOUT_BIT   = 15;
    localparam int SW_IOUT_BIT   = 14;
    localparam int SW_INPUT_BIT  = 13;
    localparam int SW_MFR_BIT    = 12;
    localparam int VOUT_OV_BIT   = 7;
    localparam int MFR_LOG_BIT   = 3;  // valid log in mfr category
    localparam int PIN_SLAVE_LO  = 14; // pin status [15:14] slave config

    // fault line responses
    localparam logic [7:0] RESP_SHUTDOWN = 8'hC0;
    localparam logic [7:0] RESP_LATCH    = 8'h80;
    localparam logic [7:0] RESP_RETRY    = 8'h40;

    // reset values
    localparam logic [7:0]  MASK_RESET    = 8'h00;
    localparam logic [15:0] MAP_RESET     = 16'h0000;
    localparam logic [7:0]  RESP_RESET    = 8'h00;

    // log geometry
    localparam int LOG_LEN      = 147;
    localparam int HDR_LEN      = 27;
    localparam int REC_LEN      = 20;
    localparam int RAM_RECS     = 6;
    localparam int NVM_RECS     = 4;

    // temperature thresholds, degrees C
    localparam int TEMP_HIGH_C = 130;
    localparam int TEMP_LOW_C  = 125;

    // timing
    localparam int CLK_MHZ        = 25;
    localparam int RETRY_MS       = 120;
    localparam int RETRY_CYCLES   = RETRY_MS * 1000 * CLK_MHZ;

    typedef enum logic [3:0] {
        FSAL_LOG_RUN    = 4'b0001,
        FSAL_LOG_FROZEN = 4'b0010,
        FSAL_LOG_COPY   = 4'b0100,
        FSAL_LOG_HELD   = 4'b1000
    } fsal_log_state_t;

    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] input_c;
        logic [7:0] mfr;
    } fsal_cat_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } fsal_bus_t;

endpackage : fsal_pkg

// *** fsal_sva.sv ***
/* fsal_sva: port checker for fsal_top, bound to every instance.
   Assumes the single clock_i domain with synchronous reset_i. */
`timescale 1ns/1ps
module fsal_sva (
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] rdata_o,
    input wire logic [63:0] fault_event_i,
    input wire logic [1:0]  ch_enabled_i,
    input wire logic [8:0]  die_temp_i,
    input wire logic [1:0]  fault_line_i,
    input wire logic [1:0]  fault_line_o,
    input wire logic [1:0]  fault_line_oe_n_o,
    input wire logic        alert_n_o,
    input wire logic [1:0]  ch_shutdown_o,
    input wire logic        nvm_copy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // ========
    // shadow of line response; shutdown only applies under one code
    logic [7:0] resp;
    always_ff @(posedge clock_i) begin
        if (reset_i) resp <= fsal_pkg::RESP_RESET;
        else if (wr_i && addr_i == fsal_pkg::ADDR_LINE_RESP) resp <= wdata_i[7:0];
    end
    // no event and no write, so no status can be set
    sequence quiet_s;
        fault_event_i == 64'h0 && !wr_i;
    endsequence
    // clear, restore or restart without the unsafe or log-valid bits; set would win over clear
    sequence clear_s;
        wr_i && addr_i == fsal_pkg::ADDR_COMMAND && wdata_i[2:0] != 3'h0
            && wdata_i[7:5] == 3'h0 && fault_event_i == 64'h0;
    endsequence
    // ========
    summary_bit_a: assert property (rd_i && addr_i == fsal_pkg::ADDR_STATUS_WORD
        |=> rdata_o[fsal_pkg::SB_NONE_ABOVE] == |rdata_o[15:12]) else $error("summary bit wrong");
    reset_out_a: assert property ($past(reset_i) |-> alert_n_o
        && fault_line_oe_n_o == 2'h3 && ch_shutdown_o == 2'h0) else $error("reset outputs wrong");
    busy_alert_a: assert property (wr_i && addr_i == fsal_pkg::ADDR_COMMAND
        && wdata_i[fsal_pkg::CMD_UNSAFE] && ch_enabled_i != 2'h0 |-> ##[1:4] !alert_n_o)
        else $error("busy did not raise alert");
    clear_release_a: assert property (quiet_s ##1 clear_s ##1 quiet_s [*3] |-> alert_n_o)
        else $error("alert held after clear");
    line_shutdown_a: assert property ((resp == fsal_pkg::RESP_SHUTDOWN
        && fault_line_i != 2'h3) [*5] |-> ch_shutdown_o == 2'h3) else $error("no shutdown");
    line_drive_a: assert property (fault_line_o == 2'h0)
        else $error("fault line driven high");
    copy_pulse_a: assert property (nvm_copy_o |=> !nvm_copy_o)
        else $error("copy pulse too long");
    hot_defer_a: assert property ((int'(die_temp_i) > fsal_pkg::TEMP_HIGH_C) [*4]
        |-> !nvm_copy_o) else $error("copy while hot");
endmodule : fsal_sva

bind fsal_top fsal_sva u_sva (.*);

// *** fsal_far_end.sv ***
/* fsal_far_end: other controllers on the fault lines and the host link clock.
   Assumes the bench raises frame_i only around host transfers. */
`timescale 1ns/1ps
module fsal_far_end (
    input  wire logic [1:0] line_oe_n_i,
    input  wire logic [1:0] ext_pull_i,
    input  wire logic       frame_i,
    output logic [1:0]      line_o,
    output logic            link_clk_o
);
    // ========
    // pulled-up open-drain lines: any party pulling wins
    assign line_o = line_oe_n_i & ~ext_pull_i;
    // link clock idles high, toggles only inside a frame
    initial link_clk_o = 1'b1;
    always #160 link_clk_o = frame_i ? ~link_clk_o : 1'b1;
endmodule : fsal_far_end

// *** fsal_top_tb.sv ***
/* fsal_top_tb: self-checking bench for fsal_top.
   Assumes fsal_far_end resolves the fault lines and makes the link clock. */
`timescale 1ns/1ps
module fsal_top_tb;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic [63:0] fault_event_i = 64'h0;
    logic [1:0]  fault_active_i = 2'h0;
    logic [1:0]  ch_enabled_i = 2'h0;
    logic [1:0]  ext_pull = 2'h0;
    logic [8:0]  die_temp_i = 9'h019;
    logic        frame = 1'b0;
    logic [15:0] rdata_o, v;
    logic [1:0]  fault_line_i, fault_line_o, fault_line_oe_n_o, ch_shutdown_o, soft_start_o;
    logic        link_clk_i, alert_n_o, nvm_copy_o;
    logic [7:0]  m;
    int          errors = 0, checks = 0, seen, ch, cat, b;
    // ========
    // retry interval shortened so a retry fits in a short run
    fsal_top #(.RETRY_COUNT(20)) DUT (.*);
    fsal_far_end u_far (.line_oe_n_i(fault_line_oe_n_o), .ext_pull_i(ext_pull),
        .frame_i(frame), .line_o(fault_line_i), .link_clk_o(link_clk_i));
    always #20 clock_i = ~clock_i;
    // ========
    function automatic int idx(input int c, input int k, input int i);
        return c * 32 + (3 - k) * 8 + i;
    endfunction : idx
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : w
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] k, input logic [15:0] e,
                      input string n);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(n, e, rdata_o & k);
    endtask : rd
    task automatic ev(input int i);
        @(posedge clock_i);
        fault_event_i <= 64'h1 << i;
        @(posedge clock_i);
        fault_event_i <= 64'h0;
    endtask : ev
    task automatic al(input logic e);
        w(4);
        chk("alert_n", 16'(e), 16'(alert_n_o));
    endtask : al
    // counts cycles in which the chosen output is high
    task automatic watch(input int n, input int sel);
        seen = 0;
        repeat (n) begin
            w(1);
            v = {13'h0, |soft_start_o, nvm_copy_o, alert_n_o};
            if (v[sel] === 1'b1) seen++;
        end
    endtask : watch
    task automatic rst();
        reset_i <= 1'b1;
        w(8);
        reset_i <= 1'b0;
    endtask : rst
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    // hang guard: the sequence needs about 600 cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        end_of_test();
    end
    // ========
    initial begin
        void'($urandom(32'hCBBE));
        rst();
        wr(fsal_pkg::ADDR_COMMAND, 16'h00C0);
        rd(fsal_pkg::ADDR_CAT_BASE + 8'h03, 16'h0008, 16'h0008, "log bit");
        rd(fsal_pkg::ADDR_LOG_STATE, 16'h0030, 16'h0030, "log flags");
        wr(fsal_pkg::ADDR_COMMAND, 16'h0001);
        rd(fsal_pkg::ADDR_LOG_STATE, 16'h000F, 16'(fsal_pkg::FSAL_LOG_HELD), "held");
        wr(fsal_pkg::ADDR_COMMAND, 16'h0008);
        rd(fsal_pkg::ADDR_LOG_STATE, 16'h003F, 16'(fsal_pkg::FSAL_LOG_RUN), "run");
        rd(fsal_pkg::ADDR_LOG_COUNT, 16'hFFFF, 16'h0000, "empty count");
        // random masks; first pass masks a whole category
        for (int k = 0; k < 12; k++) begin
            ch = $urandom_range(1);
            cat = $urandom_range(3);
            b = $urandom_range(7);
            m = (k == 0) ? 8'hFF : 8'($urandom);
            wr(fsal_pkg::ADDR_MASK_BASE + 8'(ch * 4 + cat), {8'h00, m});
            ev(idx(ch, cat, b));
            al(m[b]);
            rd(fsal_pkg::ADDR_CAT_BASE + 8'(ch * 4 + cat), 16'h00FF, 16'h1 << b, "status");
            wr(fsal_pkg::ADDR_CAT_BASE + 8'(ch * 4 + cat), 16'h1 << b);
            al(1'b1);
            wr(fsal_pkg::ADDR_MASK_BASE + 8'(ch * 4 + cat), 16'h0000);
        end
        wr(fsal_pkg::ADDR_PINS, 16'h3FFF);
        wr(fsal_pkg::ADDR_COMMON, 16'hFFFF);
        al(1'b1);
        wr(fsal_pkg::ADDR_PINS, 16'h0000);
        // clear, restore, restart each release the alert
        for (int k = 0; k < 3; k++) begin
            ev(idx(0, 0, 7));
            al(1'b0);
            rd(fsal_pkg::ADDR_STATUS_WORD, 16'h8001, 16'h8001, "word");
            wr(fsal_pkg::ADDR_COMMAND, 16'h1 << k);
            al(1'b1);
        end
        ev(idx(1, 2, 3));
        wr(fsal_pkg::ADDR_COMMAND, 16'h0010);
        frame <= 1'b1;
        watch(40, 0);
        frame <= 1'b0;
        chk("ara release", 16'h1, 16'(seen != 0));
        wr(fsal_pkg::ADDR_COMMAND, 16'h0001);
        wr(fsal_pkg::ADDR_CONTROL, 16'h0001);
        ev(idx(0, 1, 2));
        al(1'b0);
        wr(fsal_pkg::ADDR_CONTROL, 16'h0000);
        wr(fsal_pkg::ADDR_CONTROL, 16'h0001);
        al(1'b1);
        ch_enabled_i <= 2'h2;
        rd(fsal_pkg::ADDR_COMMON, 16'h000F, 16'h0002, "poll");
        wr(fsal_pkg::ADDR_COMMAND, 16'h0020);
        al(1'b0);
        rd(fsal_pkg::ADDR_STATUS_BYTE, 16'h0080, 16'h0080, "busy");
        wr(fsal_pkg::ADDR_STATUS_BYTE, 16'h0080);
        al(1'b1);
        ch_enabled_i <= 2'h0;
        wr(fsal_pkg::ADDR_LINE_MAP, 16'h0080);
        wr(fsal_pkg::ADDR_LINE_RESP, {8'h00, fsal_pkg::RESP_LATCH});
        ev(idx(0, 0, 7));
        w(20);
        chk("line latched", 16'h2, 16'(fault_line_oe_n_o));
        wr(fsal_pkg::ADDR_CAT_BASE, 16'h0080);
        w(4);
        chk("line freed", 16'h3, 16'(fault_line_oe_n_o));
        wr(fsal_pkg::ADDR_LINE_RESP, {8'h00, fsal_pkg::RESP_RETRY});
        ev(idx(0, 0, 7));
        watch(60, 2);
        chk("retry start", 16'h1, 16'(seen != 0));
        wr(fsal_pkg::ADDR_CAT_BASE, 16'h0080);
        wr(fsal_pkg::ADDR_LINE_RESP, {8'h00, fsal_pkg::RESP_SHUTDOWN});
        ext_pull <= 2'h1;
        w(6);
        chk("shutdown", 16'h3, 16'(ch_shutdown_o));
        ext_pull <= 2'h0;
        rd(fsal_pkg::ADDR_LOG_COUNT, 16'hFFFF, 16'h0000, "no log");
        rst();
        ch_enabled_i <= 2'h1;
        die_temp_i <= 9'd140;
        repeat (30) wr(fsal_pkg::ADDR_RECORD_IN, 16'($urandom_range(255)));
        ev(idx(0, 0, 6));
        watch(20, 1);
        chk("hot copy", 16'h0, 16'(seen));
        die_temp_i <= 9'd120;
        watch(20, 1);
        chk("copy", 16'h1, 16'(seen));
        rd(fsal_pkg::ADDR_LOG_COUNT, 16'hFFFF, 16'd147, "count");
        end_of_test();
    end
endmodule : fsal_top_tb
